// ### hdl/temp_sensor_config_readout.sv
`timescale 1ns/1ps
// How it works
// R1: soft reset restores all configuration defaults except the heater bit.
// R2: soft reset keeps the device busy for 15 ms (750000 clocks); addresses are refused until then.
// R3: master reads the register and writes reserved bits back unchanged.
// R4: resolution bits 7 and 0 default to 00; 01=12, 10=13, 11=11 bit.
// R5: bit 6 is read-only supply-low flag, refreshed after each measurement.
// R6: bit 2 enables the heater, default off.
// R7: with bit 1 clear, each measurement command reloads stored settings except heater.
// R8: bit 1 defaults to 1, so per-measurement reload is off.
// R9: checksum is CRC-8 with polynomial x^8+x^5+x^4+1.
// R10: a stored identification code can be read over the bus.
// R11: result goes out as two bytes, msb byte first, msb bit first.
// R12: each sent byte is followed by one ack slot driven by the master.
// R13: master clears the two status bits before converting.
// R14: master converts as -46.85 + 175.72 * value / 2^16.
// R15: header is address 1001010 plus direction bit, 1 read, 0 write.
// R16: device acks each good byte by pulling data low in the ninth clock.
// R17: upper status bit is 0 for temperature; lower one unassigned.
// R18: checksum starts at zero, runs msb first over both result bytes.
module temp_sensor_config_readout import sensor_pkg::*; #(
	parameter int RESET_CYCLES = SOFT_RESET_CYCLES,
	parameter logic [2:0] RSV_DEFAULT = 3'h0,
	parameter logic [31:0] ID_CODE = 32'h5a3c_9617 // arbitrary value
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [13:0] temp_data_i,
	input wire logic temp_valid_i,
	input wire logic supply_low_i,
	output logic meas_start_o,
	output logic heater_en_o,
	output logic [1:0] resolution_o,
	output logic busy_o
);
	localparam logic [7:0] NV_IMAGE = CFG_RESET | {2'h0, RSV_DEFAULT, 3'h0};

	bus_state_t state_reg, state_next;
	read_src_t src_reg, src_next;
	logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
	logic [3:0] bitcnt_reg, bitcnt_next;
	logic [7:0] shift_reg, shift_next;
	logic rw_reg, rw_next, wr_expect_reg, wr_expect_next, acked_reg, acked_next;
	logic [2:0] txidx_reg, txidx_next;
	logic [7:0] cfg_reg, cfg_next;
	logic [13:0] result_reg, result_next;
	logic meas_pend_reg, meas_pend_next, meas_done_reg, meas_done_next;
	logic busy_reg, busy_next;
	logic [RST_CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
	logic sda_oe_reg, sda_oe_next, meas_start_reg, meas_start_next;
	logic scl_rise, scl_fall, start_evt, stop_evt, addr_ok, do_reset, do_meas, do_cfg_wr;
	logic [15:0] result_word;
	logic [7:0] crc_a, crc_b;

	assign scl_rise = scl_i & ~scl_q_reg;
	assign scl_fall = ~scl_i & scl_q_reg;
	assign start_evt = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
	assign stop_evt = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
	assign result_word = {result_reg, STATUS_TYPE_TEMP, STATUS_SPARE}; // R17

	crc8_step #(.POLY(CRC_POLY)) crc_hi (.crc_i(CRC_INIT), .data_i(result_word[15:8]), .crc_o(crc_a)); // R18
	crc8_step #(.POLY(CRC_POLY)) crc_lo (.crc_i(crc_a), .data_i(result_word[7:0]), .crc_o(crc_b)); // R9

	function automatic logic [7:0] tx_byte(input read_src_t src, input logic [2:0] idx, input logic [7:0] cfg,
		input logic [15:0] word, input logic [7:0] crc);
		logic [7:0] b;
		b = IDLE_BYTE;
		unique case (src)
			SRC_CFG: if (idx == 3'h0) b = cfg;
			SRC_MEAS: begin
				if (idx == 3'h0) b = word[15:8]; // R11
				else if (idx == 3'h1) b = word[7:0];
				else if (idx == 3'h2) b = crc;
			end
			SRC_ID: if (idx < ID_BYTES) b = ID_CODE[8'(31 - 8 * int'(idx)) -: 8]; // R10
			SRC_NONE: b = IDLE_BYTE;
		endcase
		return b;
	endfunction

	always_comb begin
		logic [7:0] nb;
		nb = IDLE_BYTE;
		state_next = state_reg;
		src_next = src_reg;
		scl_q_next = scl_i;
		sda_q_next = sda_i;
		bitcnt_next = bitcnt_reg;
		shift_next = shift_reg;
		rw_next = rw_reg;
		wr_expect_next = wr_expect_reg;
		acked_next = acked_reg;
		txidx_next = txidx_reg;
		cfg_next = cfg_reg;
		result_next = result_reg;
		meas_pend_next = meas_pend_reg;
		meas_done_next = meas_done_reg;
		busy_next = busy_reg;
		rst_cnt_next = rst_cnt_reg;
		sda_oe_next = sda_oe_reg;
		meas_start_next = 1'b0;
		addr_ok = 1'b0;
		do_reset = 1'b0;
		do_meas = 1'b0;
		do_cfg_wr = 1'b0;

		if (busy_reg) begin
			if (rst_cnt_reg == '0) begin
				busy_next = 1'b0;
			end else begin
				rst_cnt_next = rst_cnt_reg - 1'b1; // R2
			end
		end
		if (temp_valid_i && meas_pend_reg) begin
			result_next = temp_data_i;
			meas_done_next = 1'b1;
			meas_pend_next = 1'b0;
			cfg_next[CFG_SUPPLY_LOW] = supply_low_i; // R5
		end

		if (start_evt) begin
			state_next = ST_ADDR;
			bitcnt_next = 4'h0;
			sda_oe_next = 1'b0;
		end else if (stop_evt) begin
			state_next = ST_IDLE;
			sda_oe_next = 1'b0;
			wr_expect_next = 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: sda_oe_next = 1'b0;
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_i};
						bitcnt_next = bitcnt_reg + 4'h1;
					end else if (scl_fall && bitcnt_reg == 4'h8) begin
						if (state_reg == ST_ADDR) begin
							addr_ok = shift_reg[7:1] == DEV_ADDR && !busy_reg
								&& !(shift_reg[0] && src_reg == SRC_MEAS && !meas_done_reg); // R15
							rw_next = shift_reg[0];
							sda_oe_next = addr_ok; // R16
							state_next = addr_ok ? ST_ADDR_ACK : ST_IDLE; // R2
						end else begin
							sda_oe_next = 1'b1; // R16
							state_next = ST_RX_ACK;
							if (wr_expect_reg) begin
								do_cfg_wr = 1'b1;
								wr_expect_next = 1'b0;
								// a flag refresh in this same cycle is kept
								cfg_next = (shift_reg & ~CFG_LOW_MASK) | (cfg_next & CFG_LOW_MASK); // R6
							end else begin
								unique case (shift_reg)
									CMD_MEAS_HOLD, CMD_MEAS_NOHOLD: do_meas = 1'b1;
									CMD_WRITE_CFG: wr_expect_next = 1'b1;
									CMD_READ_CFG: src_next = SRC_CFG;
									CMD_SOFT_RESET: do_reset = 1'b1;
									CMD_READ_ID: src_next = SRC_ID;
									default: src_next = src_reg;
								endcase
							end
						end
					end
				end
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (scl_fall) begin
						bitcnt_next = 4'h0;
						if (state_reg == ST_ADDR_ACK && rw_reg) begin
							nb = tx_byte(src_reg, 3'h0, cfg_reg, result_word, crc_b);
							shift_next = nb;
							txidx_next = 3'h0;
							sda_oe_next = ~nb[7];
							state_next = ST_TX;
						end else begin
							sda_oe_next = 1'b0;
							state_next = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bitcnt_next = bitcnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (bitcnt_reg == 4'h8) begin
							sda_oe_next = 1'b0; // R12
							state_next = ST_TX_ACK;
						end else begin
							shift_next = {shift_reg[6:0], 1'b1};
							sda_oe_next = ~shift_reg[6]; // R11
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						acked_next = ~sda_i; // R12
					end else if (scl_fall) begin
						bitcnt_next = 4'h0;
						if (acked_reg) begin
							txidx_next = (txidx_reg == 3'h7) ? txidx_reg : txidx_reg + 3'h1;
							nb = tx_byte(src_reg, txidx_next, cfg_reg, result_word, crc_b);
							shift_next = nb;
							sda_oe_next = ~nb[7];
							state_next = ST_TX;
						end else begin
							sda_oe_next = 1'b0;
							state_next = ST_IDLE;
						end
					end
				end
			endcase
		end

		if (do_meas) begin
			meas_start_next = 1'b1;
			meas_pend_next = 1'b1;
			meas_done_next = 1'b0;
			src_next = SRC_MEAS;
			if (!cfg_reg[CFG_NO_RELOAD]) begin
				cfg_next = (NV_IMAGE & ~(CFG_HEATER_MASK | CFG_LOW_MASK))
					| (cfg_next & (CFG_HEATER_MASK | CFG_LOW_MASK)); // R7
			end
		end
		if (do_reset) begin
			cfg_next = (NV_IMAGE & ~CFG_HEATER_MASK) | (cfg_reg & CFG_HEATER_MASK); // R1
			busy_next = 1'b1;
			rst_cnt_next = RST_CNT_W'(RESET_CYCLES - 1); // R2
			meas_pend_next = 1'b0;
			meas_done_next = 1'b0;
			src_next = SRC_NONE;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			src_reg <= SRC_NONE;
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
			bitcnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			wr_expect_reg <= 1'b0;
			acked_reg <= 1'b0;
			txidx_reg <= 3'h0;
			cfg_reg <= NV_IMAGE; // R4 R8
			result_reg <= 14'h0000;
			meas_pend_reg <= 1'b0;
			meas_done_reg <= 1'b0;
			busy_reg <= 1'b0;
			rst_cnt_reg <= '0;
			sda_oe_reg <= 1'b0;
			meas_start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			src_reg <= src_next;
			scl_q_reg <= scl_q_next;
			sda_q_reg <= sda_q_next;
			bitcnt_reg <= bitcnt_next;
			shift_reg <= shift_next;
			rw_reg <= rw_next;
			wr_expect_reg <= wr_expect_next;
			acked_reg <= acked_next;
			txidx_reg <= txidx_next;
			cfg_reg <= cfg_next;
			result_reg <= result_next;
			meas_pend_reg <= meas_pend_next;
			meas_done_reg <= meas_done_next;
			busy_reg <= busy_next;
			rst_cnt_reg <= rst_cnt_next;
			sda_oe_reg <= sda_oe_next;
			meas_start_reg <= meas_start_next;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = sda_oe_reg;
	assign meas_start_o = meas_start_reg;
	assign heater_en_o = cfg_reg[CFG_HEATER];
	assign resolution_o = {cfg_reg[CFG_RES_HI], cfg_reg[CFG_RES_LO]};
	assign busy_o = busy_reg;

	function automatic logic [7:0] crc_ref(input logic [15:0] w);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_soft_reset_heater: assert property (do_reset |=> heater_en_o == $past(heater_en_o)
		&& resolution_o == RES_14BIT && cfg_reg[CFG_NO_RELOAD]) else $error("soft reset lost heater or defaults"); // R1
	a_busy_refuse: assert property (do_reset |=> busy_o [*8]) else $error("busy dropped early"); // R2
	a_busy_nack: assert property (busy_reg && state_reg == ST_ADDR && scl_fall && bitcnt_reg == 4'h8 && !start_evt
		&& !stop_evt |=> state_reg == ST_IDLE && !sda_oe_o) else $error("address acked while busy"); // R2
	a_supply_flag: assert property (temp_valid_i && meas_pend_reg && !do_reset |=> cfg_reg[CFG_SUPPLY_LOW] == $past(supply_low_i))
		else $error("supply flag not refreshed"); // R5
	a_cfg_write: assert property (do_cfg_wr |=> heater_en_o == $past(shift_reg[CFG_HEATER]) // R6
		&& resolution_o == {$past(shift_reg[CFG_RES_HI]), $past(shift_reg[CFG_RES_LO])}
		&& cfg_reg[CFG_SUPPLY_LOW] == ($past(temp_valid_i && meas_pend_reg) ? $past(supply_low_i)
		: $past(cfg_reg[CFG_SUPPLY_LOW]))) else $error("config write wrong");
	a_reload_on: assert property (do_meas && !do_reset && !cfg_reg[CFG_NO_RELOAD] |=> resolution_o == RES_14BIT
		&& cfg_reg[CFG_NO_RELOAD] && heater_en_o == $past(heater_en_o)) else $error("reload missing"); // R7
	a_reload_off: assert property (do_meas && cfg_reg[CFG_NO_RELOAD] |=> $stable(cfg_reg[5:0])
		&& $stable(resolution_o)) else $error("config changed without reload"); // R8
	a_crc_value: assert property (crc_b == crc_ref(result_word)) else $error("checksum mismatch"); // R9
	a_msb_first: assert property (state_reg == ST_TX && bitcnt_reg < 4'h8 |-> sda_oe_o == ~shift_reg[7])
		else $error("bit order wrong"); // R11
	a_ack_release: assert property (state_reg == ST_TX_ACK |-> !sda_oe_o) else $error("device drove ack slot"); // R12
	a_addr_ack: assert property (state_reg == ST_ADDR_ACK |-> sda_oe_o) else $error("address not acked"); // R16
	a_status_bits: assert property (result_word[1:0] == 2'h0) else $error("status bits wrong"); // R17

	c_soft_reset: cover property (do_reset ##1 busy_o);
	c_meas_read: cover property (state_reg == ST_TX && src_reg == SRC_MEAS && txidx_reg == 3'h2);
	c_cfg_write: cover property (do_cfg_wr);
	c_busy_refused: cover property (busy_reg && state_reg == ST_ADDR && scl_fall && bitcnt_reg == 4'h8);
endmodule

// ### hdl/sensor_pkg.sv
package sensor_pkg;

	// clock and soft reset timing
	localparam int CLK_HZ = 50_000_000;
	localparam int SOFT_RESET_MS = 15;
	localparam int SOFT_RESET_CYCLES = SOFT_RESET_MS * (CLK_HZ / 1000);
	localparam int RST_CNT_W = 20;

	// bus header and command codes
	localparam logic [6:0] DEV_ADDR = 7'h4a;
	localparam logic [7:0] CMD_MEAS_HOLD = 8'he3;
	localparam logic [7:0] CMD_MEAS_NOHOLD = 8'hf3;
	localparam logic [7:0] CMD_WRITE_CFG = 8'he6;
	localparam logic [7:0] CMD_READ_CFG = 8'he7;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hfe;
	localparam logic [7:0] CMD_READ_ID = 8'hfa;

	// configuration register layout
	localparam int CFG_RES_HI = 7;
	localparam int CFG_SUPPLY_LOW = 6;
	localparam int CFG_RSV_LO = 3;
	localparam int CFG_HEATER = 2;
	localparam int CFG_NO_RELOAD = 1;
	localparam int CFG_RES_LO = 0;
	localparam logic [7:0] CFG_RESET = 8'h02;
	localparam logic [7:0] CFG_HEATER_MASK = 8'h04;
	localparam logic [7:0] CFG_LOW_MASK = 8'h40;
	localparam logic [7:0] CFG_RSV_MASK = 8'h38;

	// resolution codes {bit7, bit0}
	localparam logic [1:0] RES_14BIT = 2'h0;
	localparam logic [1:0] RES_12BIT = 2'h1;
	localparam logic [1:0] RES_13BIT = 2'h2;
	localparam logic [1:0] RES_11BIT = 2'h3;

	// result framing and checksum
	localparam logic STATUS_TYPE_TEMP = 1'b0;
	localparam logic STATUS_SPARE = 1'b0;
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [2:0] ID_BYTES = 3'h4;
	localparam logic [7:0] IDLE_BYTE = 8'hff;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} bus_state_t;
	typedef enum logic [1:0] {SRC_NONE, SRC_CFG, SRC_MEAS, SRC_ID} read_src_t;

endpackage

// ### hdl/crc8_step.sv
`timescale 1ns/1ps
module crc8_step import sensor_pkg::*; #(
	parameter logic [7:0] POLY = CRC_POLY
) (
	input wire logic [7:0] crc_i,
	input wire logic [7:0] data_i,
	output logic [7:0] crc_o
);
	// one byte through the checksum, msb first
	always_comb begin
		logic [7:0] c;
		c = crc_i ^ data_i;
		for (int i = 0; i < 8; i++) begin
			if (c[7]) begin
				c = {c[6:0], 1'b0} ^ POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc_o = c;
	end
endmodule

// ### testbench/bus_master.sv
`timescale 1ns/1ps
// far-side bus master: owns the clock line, shares the pulled-up data line
module bus_master (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#2;
	endtask
	// start or repeated start, leaves the clock low
	task automatic start_cond();
		sda_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b0;
		tick(2);
	endtask
	task automatic stop_cond();
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b1;
		tick(4);
	endtask
	// data only moves while the clock is low
	task automatic bit_slot(input logic d, output logic q);
		sda_o = d;
		tick(4);
		scl_o = 1'b1;
		tick(2);
		q = sda_i;
		tick(2);
		scl_o = 1'b0;
		tick(2);
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic q;
		for (int i = 7; i >= 0; i--) bit_slot(b[i], q);
		bit_slot(1'b1, q);
		ack = ~q;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] b);
		logic q;
		for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
		bit_slot(last, q);
	endtask
endmodule

// ### testbench/tb_temp_sensor_config_readout.sv
`timescale 1ns/1ps
module tb_temp_sensor_config_readout import sensor_pkg::*;
;
	localparam int RST_CYC = 200;
	localparam logic [2:0] RSV = 3'h5;
	localparam logic [31:0] ID_VAL = 32'hc3a5_0f1e; // arbitrary value
	localparam logic [7:0] HDR_W = {DEV_ADDR, 1'b0};
	localparam logic [7:0] HDR_R = {DEV_ADDR, 1'b1};
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic scl, m_sda, sda_w, sda_o, sda_oe_o, meas_start_o, heater_en_o, busy_o;
	logic [13:0] temp_data_i = 14'h0000;
	logic temp_valid_i = 1'b0;
	logic supply_low_i = 1'b0;
	logic [1:0] resolution_o;
	int miscompares = 0;
	int n_compared = 0;
	int n_meas = 0;
	int m0;
	logic ack;
	logic [7:0] rsv_img;
	logic [7:0] rb [4];
	real t_c;
	always #10 clock_i = ~clock_i;
	assign sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1);
	always @(posedge clock_i) if (meas_start_o === 1'b1) n_meas++;
	temp_sensor_config_readout #(.RESET_CYCLES(RST_CYC), .RSV_DEFAULT(RSV), .ID_CODE(ID_VAL))
	u_temp_sensor_config_readout (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .temp_data_i(temp_data_i), .temp_valid_i(temp_valid_i),
		.supply_low_i(supply_low_i), .meas_start_o(meas_start_o), .heater_en_o(heater_en_o),
		.resolution_o(resolution_o), .busy_o(busy_o));
	bus_master u_bus_master (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
	task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic chk_flag(input string name, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %b seen %b", name, e, g);
		end
	endtask
	task automatic finish_test();
		if (miscompares == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c, input logic has_d, input logic [7:0] d);
		u_bus_master.start_cond();
		u_bus_master.wr_byte(HDR_W, ack);
		chk_flag("hdr_ack", 1'b1, ack);
		u_bus_master.wr_byte(c, ack);
		chk_flag("cmd_ack", 1'b1, ack);
		if (has_d) begin
			u_bus_master.wr_byte(d, ack);
			chk_flag("data_ack", 1'b1, ack);
		end
		u_bus_master.stop_cond();
	endtask
	task automatic rd(input int n, output logic a);
		u_bus_master.start_cond();
		u_bus_master.wr_byte(HDR_R, a);
		if (a) for (int i = 0; i < n; i++) u_bus_master.rd_byte(i == n - 1, rb[i]);
		u_bus_master.stop_cond();
	endtask
	task automatic read_cfg(input logic [7:0] e);
		cmd(CMD_READ_CFG, 1'b0, 8'h00);
		rd(1, ack);
		chk_byte("cfg", e, rb[0]);
	endtask
	task automatic conv_done(input logic [13:0] t, input logic low);
		@(posedge clock_i);
		#2;
		temp_data_i = t;
		supply_low_i = low;
		temp_valid_i = 1'b1;
		@(posedge clock_i);
		#2;
		temp_valid_i = 1'b0;
	endtask
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
		return c;
	endfunction
	initial begin
		repeat (16) @(posedge clock_i);
		#2;
		rst_n_i = 1'b1;
		read_cfg({2'b00, RSV, 3'b010});
		chk_flag("heater", 1'b0, heater_en_o);
		// foreign address is left unanswered
		u_bus_master.start_cond();
		u_bus_master.wr_byte(8'h96, ack);
		u_bus_master.stop_cond();
		chk_flag("bad_addr_ack", 1'b0, ack);
		// read-modify-write through every resolution code
		cmd(CMD_READ_CFG, 1'b0, 8'h00);
		rd(1, ack);
		rsv_img = rb[0] & 8'h38;
		for (int k = 0; k < 4; k++) begin
			cmd(CMD_WRITE_CFG, 1'b1, rsv_img | {k[1], 5'h00, 1'b1, k[0]} | 8'h04);
			chk_byte("res", {6'h00, k[1:0]}, {6'h00, resolution_o});
			read_cfg(rsv_img | {k[1], 5'h00, 1'b1, k[0]} | 8'h04);
		end
		chk_flag("heater", 1'b1, heater_en_o);
		// result refused while pending, then three bytes
		m0 = n_meas;
		cmd(CMD_MEAS_NOHOLD, 1'b0, 8'h00);
		chk_flag("meas_start", 1'b1, n_meas == m0 + 1);
		rd(3, ack);
		chk_flag("poll_ack", 1'b0, ack);
		conv_done(14'h18d4, 1'b1);
		rd(3, ack);
		chk_flag("poll_ack", 1'b1, ack);
		chk_byte("msb", 8'h63, rb[0]);
		chk_byte("lsb", 8'h50, rb[1]);
		chk_byte("status", 8'h00, rb[1] & 8'h03);
		chk_byte("crc", crc8(16'h6350), rb[2]);
		t_c = -46.85 + 175.72 * $itor({rb[0], rb[1] & 8'hfc}) / 65536.0;
		chk_flag("temp_c", 1'b1, $rtoi(t_c * 100.0 + 0.5) == 2132);
		read_cfg(rsv_img | 8'hc7);
		// reload on measurement when bit 1 is clear
		cmd(CMD_WRITE_CFG, 1'b1, rsv_img | 8'h85);
		m0 = n_meas;
		cmd(CMD_MEAS_HOLD, 1'b0, 8'h00);
		chk_flag("meas_start", 1'b1, n_meas == m0 + 1);
		chk_byte("res", 8'h00, {6'h00, resolution_o});
		chk_flag("heater", 1'b1, heater_en_o);
		conv_done(14'h0000, 1'b0);
		read_cfg({2'b00, RSV, 3'b110});
		// soft reset keeps the heater and refuses the bus while busy
		cmd(CMD_WRITE_CFG, 1'b1, rsv_img | 8'h87);
		cmd(CMD_SOFT_RESET, 1'b0, 8'h00);
		chk_flag("busy", 1'b1, busy_o);
		rd(1, ack);
		chk_flag("busy_ack", 1'b0, ack);
		for (int i = 0; i < 400 && busy_o !== 1'b0; i++) begin
			@(posedge clock_i);
			#2;
		end
		if (busy_o !== 1'b0) begin
			miscompares++;
			finish_test();
		end
		// unknown command is acked and leaves the configuration alone
		cmd(8'h5a, 1'b0, 8'h00);
		read_cfg({2'b00, RSV, 3'b110});
		chk_byte("res", 8'h00, {6'h00, resolution_o});
		// identification code, msb first
		cmd(CMD_READ_ID, 1'b0, 8'h00);
		rd(4, ack);
		for (int i = 0; i < 4; i++) chk_byte("id", ID_VAL[31 - 8 * i -: 8], rb[i]);
		finish_test();
	end
endmodule
